// ==== status_defines.svh ====
// timing and encoding constants for the module status indicator block
// assumes a 200 MHz system clock
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH
`define CLK_HZ           200000000
`define FLASH_BASE_HZ    4
// one tick per quarter second: 2 Hz toggles every tick, 1 Hz every second tick
`define TICK_CYCLES      (`CLK_HZ / `FLASH_BASE_HZ)
`define TICK_W           26
`define IN_CH            8
`define OUT_CH           4
`define LOGIC_PERIOD_CYCLES 16'h0800
`define LOGIC_W          16
`endif

// ==== status_pkg.sv ====
// shared types for the module status indicator block
// assumes status_defines.svh is on the include path
package status_pkg;
    typedef enum logic [3:0] {
        ST_BOOT  = 4'b0001,
        ST_STOP  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_FAIL  = 4'b1000
    } run_state_e;
    typedef struct packed {
        logic red;
        logic green;
    } led_s;
endpackage : status_pkg

// ==== flash_if.sv ====
// carries the shared flash phases from the divider to the main logic
// assumes one clk_sys domain
interface flash_if;
    logic phase_1hz;
    logic phase_2hz;
    logic tick;
    modport src (output phase_1hz, output phase_2hz, output tick);
    modport dst (input phase_1hz, input phase_2hz, input tick);
endinterface : flash_if

// ==== flash_divider.sv ====
// shared divider producing coherent 1 Hz and 2 Hz square waves
// assumes a 200 MHz clk_sys and synchronous active-low reset
`include "status_defines.svh"
module flash_divider (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    flash_if.src      fl
);
    logic [`TICK_W-1:0] cnt_q, cnt_d;
    logic [1:0]         ph_q, ph_d;
    logic               tick_d, tick_q;

    always_comb begin
        cnt_d  = cnt_q + `TICK_W'(1);
        ph_d   = ph_q;
        tick_d = 1'b0;
        if (cnt_q == `TICK_W'(`TICK_CYCLES - 1)) begin
            cnt_d  = '0;
            ph_d   = ph_q + 2'h1;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            ph_q   <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            ph_q   <= ph_d;
            tick_q <= tick_d;
        end
    end

    // both waves have 50 percent duty from the same counter
    assign fl.phase_2hz = ph_q[0];
    assign fl.phase_1hz = ph_q[1];
    assign fl.tick      = tick_q;
endmodule : flash_divider

// ==== module_status_led_run_stop.sv ====
// run/stop state and status indicators of an expansion I/O module
// assumes pins are asynchronous; commands and faults come from same-clock logic
`include "status_defines.svh"
module module_status_led_run_stop
    import status_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    // pins
    input  wire logic                   supply_ok_pin,
    input  wire logic [`IN_CH-1:0]      input_channels,
    // boot and configuration
    input  wire logic                   boot_done,
    input  wire logic                   boot_ok,
    input  wire logic                   config_verified,
    // commands
    input  wire logic                   cmd_start,
    input  wire logic                   cmd_stop,
    // faults, two-channel flags and output requests
    input  wire logic                   crit_fault_here,
    input  wire logic                   crit_fault_other,
    input  wire logic                   field_fault,
    input  wire logic [`IN_CH-1:0]      in_fault,
    input  wire logic [`IN_CH-1:0]      in_two_channel,
    input  wire logic [`OUT_CH-1:0]     out_request,
    input  wire logic [`OUT_CH-1:0]     out_test_fault,
    // outputs
    output status_pkg::led_s            module_state_indicator,
    output logic [`IN_CH-1:0]           input_led,
    output logic [`OUT_CH-1:0]          output_led,
    output logic [`OUT_CH-1:0]          output_channels,
    output logic [`IN_CH-1:0]           input_values,
    output logic                        running,
    output logic                        first_cycle,
    output logic                        function_reset
);
    flash_if fl();

    flash_divider u_div (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .fl      (fl)
    );

    // pin synchronisers: stage one is read only by stage two
    logic                supply_s1_q, supply_s2_q;
    logic [`IN_CH-1:0]   in_s1_q, in_s2_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            supply_s1_q <= 1'b0;
            supply_s2_q <= 1'b0;
            in_s1_q     <= '0;
            in_s2_q     <= '0;
        end else begin
            supply_s1_q <= supply_ok_pin;
            supply_s2_q <= supply_s1_q;
            in_s1_q     <= input_channels;
            in_s2_q     <= in_s1_q;
        end
    end

    // run/stop state machine
    run_state_e          state_q, state_d;
    logic [`LOGIC_W-1:0] fc_cnt_q, fc_cnt_d;
    logic                fc_q, fc_d;
    logic                frst_q, frst_d;
    logic                crit;

    assign crit = crit_fault_here | crit_fault_other;

    always_comb begin
        state_d  = state_q;
        fc_cnt_d = fc_cnt_q;
        fc_d     = fc_q;
        frst_d   = 1'b0;
        unique case (state_q)
            ST_BOOT: begin
                if (boot_done) begin
                    if (!boot_ok) begin
                        state_d = ST_FAIL;
                    end else if (config_verified) begin
                        state_d = ST_RUN;
                    end else begin
                        state_d = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (cmd_start && !crit) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (crit) begin
                    state_d = ST_STOP;
                end else if (cmd_stop) begin
                    state_d = ST_STOP;
                end
            end
            ST_FAIL: begin
                state_d = ST_FAIL;
            end
        endcase
        // every entry into run, from boot or stop, is a start
        if (state_d == ST_RUN && state_q != ST_RUN) begin
            fc_d     = 1'b1;
            fc_cnt_d = `LOGIC_PERIOD_CYCLES - `LOGIC_W'(1);
            frst_d   = 1'b1;
        end else if (fc_q) begin
            if (fc_cnt_q == '0 || state_q != ST_RUN) begin
                fc_d = 1'b0;
            end else begin
                fc_cnt_d = fc_cnt_q - `LOGIC_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q  <= ST_BOOT;
            fc_cnt_q <= '0;
            fc_q     <= 1'b0;
            frst_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            fc_cnt_q <= fc_cnt_d;
            fc_q     <= fc_d;
            frst_q   <= frst_d;
        end
    end

    // indicator and output logic
    led_s                ms_d, ms_q;
    logic [`IN_CH-1:0]   inled_d, inled_q, inval_d, inval_q;
    logic [`OUT_CH-1:0]  outled_d, outled_q, outch_d, outch_q;
    logic                is_run;
    logic                ph1, ph2;

    assign is_run = (state_q == ST_RUN);
    assign ph1    = fl.phase_1hz;
    assign ph2    = fl.phase_2hz;

    always_comb begin
        ms_d = '{red: 1'b0, green: 1'b0};
        if (crit_fault_here) begin
            ms_d.red = ph2;
        end else if (crit_fault_other) begin
            ms_d.red = 1'b1;
        end else if (!supply_s2_q) begin
            ms_d = '{red: 1'b0, green: 1'b0};
        end else if (field_fault) begin
            ms_d = '{red: ph1, green: !ph1};
        end else if (state_q == ST_FAIL) begin
            ms_d.red = ph1;
        end else if (is_run) begin
            ms_d.green = 1'b1;
        end else if (state_q == ST_STOP) begin
            ms_d.green = ph1;
        end
        for (int i = 0; i < `IN_CH; i++) begin
            if (!in_fault[i]) begin
                inled_d[i] = in_s2_q[i];
            end else if (!in_s2_q[i] && in_two_channel[i]) begin
                inled_d[i] = !ph1;
            end else begin
                inled_d[i] = ph1;
            end
        end
        // run only; output channels, not input values, are also cut under a critical fault
        outch_d = (is_run && !crit) ? out_request : '0;
        inval_d = is_run ? in_s2_q : '0;
        for (int j = 0; j < `OUT_CH; j++) begin
            outled_d[j] = out_test_fault[j] ? ph1 : outch_d[j];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ms_q     <= '{red: 1'b0, green: 1'b0};
            inled_q  <= '0;
            inval_q  <= '0;
            outled_q <= '0;
            outch_q  <= '0;
        end else begin
            ms_q     <= ms_d;
            inled_q  <= inled_d;
            inval_q  <= inval_d;
            outled_q <= outled_d;
            outch_q  <= outch_d;
        end
    end

    assign module_state_indicator = ms_q;
    assign input_led              = inled_q;
    assign output_led             = outled_q;
    assign output_channels        = outch_q;
    assign input_values           = inval_q;
    assign running                = is_run;
    assign first_cycle            = fc_q;
    assign function_reset         = frst_q;
endmodule : module_status_led_run_stop

// ==== status_props.sv ====
// port assertions of the status indicator block
// assumes a bind onto module_status_led_run_stop
module status_props
    import status_pkg::*;
(
    // clock, reset and inputs
    input wire logic             clk_sys,
    input wire logic             rst_b,
    input wire logic             supply_ok_pin,
    input wire logic [7:0]       input_channels,
    input wire logic             cmd_stop,
    input wire logic             crit_fault_here,
    input wire logic             crit_fault_other,
    input wire logic [7:0]       in_fault,
    // outputs
    input wire status_pkg::led_s module_state_indicator,
    input wire logic [7:0]       input_led,
    input wire logic [3:0]       output_channels,
    input wire logic [7:0]       input_values,
    input wire logic             running,
    input wire logic             first_cycle,
    input wire logic             function_reset
);
    logic [11:0] len_q, len_d;
    always_comb len_d = first_cycle ? len_q + 12'h001 : 12'h000;
    always_ff @(posedge clk_sys) len_q <= rst_b ? len_d : 12'h000;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // pins pass a two-flop synchroniser, so four samples cover the lag
    sequence s_supply_low;
        (!supply_ok_pin && !crit_fault_here && !crit_fault_other)[*4];
    endsequence
    // function reset rides the entry edge and drops at the next one
    sequence s_reset_pulse;
        function_reset ##1 !function_reset;
    endsequence
    chk_start_flag: assert property ($rose(running) |-> first_cycle)
        else $error("first cycle flag missing");
    chk_start_clear: assert property ($rose(running) |-> s_reset_pulse)
        else $error("function reset not a single pulse");
    chk_first_len: assert property ($fell(first_cycle) && running |-> len_q == 12'h800)
        else $error("first cycle flag length wrong");
    chk_stop_cmd: assert property (running && cmd_stop |=> !running)
        else $error("stop command ignored");
    chk_crit_off: assert property (crit_fault_here || crit_fault_other |=> output_channels == 4'h0)
        else $error("outputs on under critical fault");
    chk_idle_off: assert property (!running |=> output_channels == 4'h0 && input_values == 8'h00)
        else $error("values sent outside run");
    chk_red_other: assert property (crit_fault_other && !crit_fault_here |=> module_state_indicator == 2'h2)
        else $error("indicator not steady red");
    chk_dark_supply: assert property (s_supply_low |=> module_state_indicator == 2'h0)
        else $error("indicator lit on bad supply");
    chk_input_level: assert property ((in_fault == 8'h00 && $stable(input_channels))[*4]
        |=> input_led == $past(input_channels)) else $error("input indicator not level");
endmodule : status_props

// ==== cfg_sw.sv ====
// model of the configuration tool issuing run and stop commands
// assumes calls begin just after a rising clock edge
module cfg_sw (
    // clock and commands
    input  wire logic clk_sys,
    output logic      cmd_start = 1'b0,
    output logic      cmd_stop = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic send(input logic go);
        cmd_start = go;
        cmd_stop = !go;
        @(posedge clk_sys);
        #1;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
    endtask : send
endmodule : cfg_sw

// ==== testbench.sv ====
// self-checking bench of the status indicator block
// assumes checker and command model are compiled first
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import status_pkg::*;
    logic       clk_sys = 1'b0, rst_b = 1'b0, supply_ok_pin = 1'b1, boot_done = 1'b0, boot_ok = 1'b0;
    logic       config_verified = 1'b0, crit_fault_here = 1'b0, crit_fault_other = 1'b0, field_fault = 1'b0;
    logic       cmd_start, cmd_stop, running, first_cycle, function_reset;
    logic [7:0] input_channels = 8'h00, in_fault = 8'h00, in_two_channel = 8'h00, input_led, input_values;
    logic [3:0] out_request = 4'h3, out_test_fault = 4'h0, output_led, output_channels;
    led_s       module_state_indicator;
    int         err_total = 0;
    int         checks = 0;
    cfg_sw sw (.*);
    module_status_led_run_stop DUT (.*);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic go(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : go
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // boot checks report at the first edge after reset
    task automatic boot(input logic ok, input logic ver);
        rst_b = 1'b0;
        go(5);
        rst_b = 1'b1;
        boot_done = 1'b1;
        boot_ok = ok;
        config_verified = ver;
        go(1);
        boot_done = 1'b0;
    endtask : boot
    task automatic t_run;
        int n;
        boot(1'b1, 1'b1);
        chk("running", running, 1'h1);
        chk("freset", function_reset, 1'h1);
        for (n = 0; first_cycle === 1'b1 && n < 3000; n++)
            go(1);
        chk("first", 16'(n), 16'h0800);
        chk("freset", function_reset, 1'h0);
        if (n == 3000)
            summarize();
        chk("msi", module_state_indicator, 2'h1);
        sw.send(1'b0);
        go(1);
        chk("msi", module_state_indicator, 2'h0);
        chk("out", output_channels, 4'h0);
        sw.send(1'b1);
        chk("running", running, 1'h1);
        $display("t_run done");
    endtask : t_run
    task automatic t_fault;
        crit_fault_here = 1'b1;
        go(1);
        chk("running", running, 1'h0);
        chk("msi", module_state_indicator, 2'h0);
        chk("out", output_channels, 4'h0);
        crit_fault_here = 1'b0;
        crit_fault_other = 1'b1;
        sw.send(1'b1);
        chk("running", running, 1'h0);
        chk("msi", module_state_indicator, 2'h2);
        crit_fault_other = 1'b0;
        field_fault = 1'b1;
        go(1);
        chk("msi", module_state_indicator, 2'h1);
        supply_ok_pin = 1'b0;
        go(4);
        chk("msi", module_state_indicator, 2'h0);
        field_fault = 1'b0;
        supply_ok_pin = 1'b1;
        $display("t_fault done");
    endtask : t_fault
    task automatic t_leds;
        sw.send(1'b1);
        input_channels = 8'hF0;
        // three extra stable cycles let the level assertion complete a full attempt
        go(6);
        chk("in_led", input_led, 8'hF0);
        chk("in_val", input_values, 8'hF0);
        in_fault = 8'hFF;
        in_two_channel = 8'h0F;
        out_test_fault = 4'h1;
        go(2);
        chk("in_led", input_led, 8'h0F);
        chk("out_led", output_led, 4'h2);
        out_test_fault = 4'h0;
        out_request = 4'hC;
        go(2);
        chk("out", output_channels, 4'hC);
        chk("out_led", output_led, 4'hC);
        $display("t_leds done");
    endtask : t_leds
    task automatic t_fail;
        boot(1'b0, 1'b1);
        sw.send(1'b1);
        chk("running", running, 1'h0);
        chk("in_val", input_values, 8'h00);
        boot(1'b1, 1'b0);
        sw.send(1'b1);
        chk("running", running, 1'h1);
        $display("t_fail done");
    endtask : t_fail
    initial begin
        t_run();
        t_fault();
        t_leds();
        t_fail();
        summarize();
    end
endmodule : testbench
bind module_status_led_run_stop status_props u_props (.*);
